// file: hdl/rtcatc_pkg.sv
// constants and carriers for the alarm, tamper and trim control block
// assumes one 10 MHz clock and a byte-wide register port
package rtcatc_pkg;
   // ************************************************************
   // register offsets and reset values
   // ************************************************************
   localparam logic [7:0] ADDR_ALARM_CTRL = 8'h08;
   localparam logic [7:0] ADDR_DETECTOR   = 8'h09;
   localparam logic [7:0] ADDR_CAP_TRIM   = 8'h0A;
   localparam logic [7:0] ADDR_COUNT_TRIM = 8'h0B;
   localparam logic [7:0] RST_REG         = 8'h00;
   localparam logic [3:0] FREQ_OFF        = 4'h0;
   localparam logic [3:0] FREQ_RAW        = 4'h1;
   localparam logic [1:0] RATE_CONT       = 2'h0;
   localparam logic [1:0] QSEC_LAST       = 2'h3;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_HZ        = 10_000_000;
   localparam int PULSE_MS      = 250;
   localparam int PULSE_CYC     = PULSE_MS * (CLK_HZ / 1000);
   localparam int FILT1_US      = 3900;
   localparam int FILT2_US      = 15625;
   localparam int FILT3_US      = 31250;
   localparam int FILT1_CYC     = FILT1_US * (CLK_HZ / 1_000_000);
   localparam int FILT2_CYC     = FILT2_US * (CLK_HZ / 1_000_000);
   localparam int FILT3_CYC     = FILT3_US * (CLK_HZ / 1_000_000);
   localparam int SEC_CYC       = CLK_HZ;
   localparam int PPM_STEP      = 20;
   localparam int TRIM_STEP_CYC = (CLK_HZ / 1_000_000) * PPM_STEP;
   // ************************************************************
   // register layouts
   // ************************************************************
   typedef struct packed {
      logic       alarm_repeat_select;
      logic       alarm_enable;
      logic       low_power_switch;
      logic       pin_off_in_battery;
      logic [3:0] freq_select;
   } rtcatc_alarm_s;
   typedef struct packed {
      logic       input_pullup_off;
      logic       detect_out_battery_off;
      logic       halt_on_detect;
      logic       detector_on;
      logic [1:0] input_filter_time;
      logic [1:0] input_sample_rate;
   } rtcatc_detect_s;
   typedef struct packed {
      logic [1:0] battery_cap_delta;
      logic [5:0] cap_trim;
   } rtcatc_cap_s;
endpackage : rtcatc_pkg

// file: hdl/rtcatc_top.sv
// alarm pin, tamper detector, supply switch and trim control
// assumes synchronous inputs, a byte register port and an outside status register
`timescale 1ns/1ps
module rtcatc_top #(
   parameter int PULSE_CYC = rtcatc_pkg::PULSE_CYC,
   parameter int FILT1_CYC = rtcatc_pkg::FILT1_CYC,
   parameter int FILT2_CYC = rtcatc_pkg::FILT2_CYC,
   parameter int FILT3_CYC = rtcatc_pkg::FILT3_CYC,
   parameter int SEC_CYC   = rtcatc_pkg::SEC_CYC
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       vdd_below_hys,
   input  wire logic       vdd_below_trip,
   input  wire logic       osc_32k,
   input  wire logic       alarm_match,
   input  wire logic       alarm_flag,
   input  wire logic       time_write_done,
   input  wire logic       tamper_input,
   input  wire logic       detect_clr,
   output logic            on_battery,
   output logic            irq_fout_o,
   output logic            irq_fout_oe,
   output logic            tamper_out_n_o,
   output logic            tamper_out_n_oe,
   output logic            pullup_en,
   output logic      [5:0] cap_code,
   output logic      [1:0] cap_delta,
   output logic            sec_tick,
   output logic            count_halted,
   output logic            detect_flag
);
   // ************************************************************
   // functions
   // ************************************************************
   function automatic logic [23:0] trim_len(input logic [2:0] t, input logic [23:0] base);
      logic [23:0] adj;
      adj = 24'(rtcatc_pkg::TRIM_STEP_CYC) * {22'h00_0000, t[1:0]};
      return t[2] ? base + adj : base - adj;
   endfunction : trim_len

   function automatic logic [31:0] half_len(input logic [3:0] f, input logic [23:0] l);
      logic [31:0] w;
      w = {8'h00, l};
      case (f)
         4'h2:    return w >> 13;
         4'h3:    return w >> 11;
         4'h4:    return w >> 7;
         4'h5:    return w >> 6;
         4'h6:    return w >> 5;
         4'h7:    return w >> 4;
         4'h8:    return w >> 3;
         4'h9:    return w >> 2;
         4'hA:    return w >> 1;
         4'hB:    return w;
         4'hC:    return w << 1;
         4'hD:    return w << 2;
         4'hE:    return w << 3;
         4'hF:    return w << 4;
         default: return 32'h0000_0001;
      endcase
   endfunction : half_len

   // ************************************************************
   // registers
   // ************************************************************
   rtcatc_pkg::rtcatc_alarm_s  ac;
   rtcatc_pkg::rtcatc_detect_s dc;
   rtcatc_pkg::rtcatc_cap_s    cc;
   logic [2:0]                 count_trim;
   logic [23:0]                sec_cnt;
   logic [1:0]                 qsec;
   logic [31:0]                fcnt;
   logic                       ftog;
   logic [31:0]                pulse_cnt;
   logic [31:0]                filt_cnt;
   logic                       filt_run;

   wire wr_ac = reg_wr && reg_addr == rtcatc_pkg::ADDR_ALARM_CTRL;
   wire wr_dc = reg_wr && reg_addr == rtcatc_pkg::ADDR_DETECTOR;
   wire wr_cc = reg_wr && reg_addr == rtcatc_pkg::ADDR_CAP_TRIM;
   wire wr_dt = reg_wr && reg_addr == rtcatc_pkg::ADDR_COUNT_TRIM;
   wire [7:0] next_rdata = reg_addr == rtcatc_pkg::ADDR_ALARM_CTRL ? ac :
                           reg_addr == rtcatc_pkg::ADDR_DETECTOR   ? dc :
                           reg_addr == rtcatc_pkg::ADDR_CAP_TRIM   ? cc :
                           reg_addr == rtcatc_pkg::ADDR_COUNT_TRIM ? {5'h00, count_trim} : 8'h00;

   // ************************************************************
   // supply switch and trimmed second
   // ************************************************************
   wire next_on_battery = ac.low_power_switch ? vdd_below_hys : vdd_below_hys && vdd_below_trip;
   wire [23:0] sec_len = trim_len(count_trim, 24'(SEC_CYC));
   wire s_end  = sec_cnt >= sec_len - 24'h00_0001;
   wire s_half = sec_cnt == (sec_len >> 1) - 24'h00_0001;
   wire [31:0] f_half = half_len(ac.freq_select, sec_len);

   // ************************************************************
   // alarm and frequency pin
   // ************************************************************
   wire alarm_active = ac.alarm_enable && ac.freq_select == rtcatc_pkg::FREQ_OFF;
   wire pin_gated    = on_battery && ac.pin_off_in_battery;
   wire alarm_low    = alarm_active && (ac.alarm_repeat_select ? pulse_cnt != 32'h0 : alarm_flag);
   wire fout_level   = ac.freq_select == rtcatc_pkg::FREQ_RAW ? osc_32k : ftog;
   wire next_pin_low = pin_gated ? 1'b0 :
                       ac.freq_select != rtcatc_pkg::FREQ_OFF ? !fout_level : alarm_low;
   wire pulse_load   = alarm_match && alarm_active && ac.alarm_repeat_select;

   // ************************************************************
   // tamper detector
   // ************************************************************
   wire samp_tick = dc.input_sample_rate == 2'h1 ? s_end || s_half :
                    dc.input_sample_rate == 2'h2 ? s_end :
                    s_end && qsec == rtcatc_pkg::QSEC_LAST;
   wire [31:0] filt_len = dc.input_filter_time == 2'h1 ? 32'(FILT1_CYC) :
                          dc.input_filter_time == 2'h2 ? 32'(FILT2_CYC) :
                          dc.input_filter_time == 2'h3 ? 32'(FILT3_CYC) : 32'h0;
   wire continuous = dc.input_sample_rate == rtcatc_pkg::RATE_CONT;
   wire samp_hit   = !continuous && samp_tick && tamper_input;
   wire detect_ev  = dc.detector_on && (continuous ? tamper_input :
                     (samp_hit && filt_len == 32'h0) ||
                     (filt_run && tamper_input && filt_cnt == 32'h1));
   wire next_detect_flag = detect_ev || (detect_flag && !detect_clr);
   wire next_halted      = (detect_ev && dc.halt_on_detect) || (count_halted && !time_write_done);
   wire next_out_low     = next_detect_flag && !(next_on_battery && dc.detect_out_battery_off);

   // ************************************************************
   // register file
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ac         <= rtcatc_pkg::RST_REG;
         dc         <= rtcatc_pkg::RST_REG;
         cc         <= rtcatc_pkg::RST_REG;
         count_trim <= 3'h0;
         reg_rdata  <= 8'h00;
      end
      else
      begin
         reg_rdata <= next_rdata;
         if (wr_ac)
            ac <= reg_wdata;
         if (wr_cc)
            cc <= reg_wdata;
         if (wr_dt)
            count_trim <= reg_wdata[2:0];
         if (wr_dc)
            dc <= reg_wdata;
         else if (time_write_done)
            dc.halt_on_detect <= 1'b0;
      end
   end

   // ************************************************************
   // timebase, pulse and frequency counters
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sec_cnt   <= 24'h00_0000;
         qsec      <= 2'h0;
         sec_tick  <= 1'b0;
         fcnt      <= 32'h0000_0000;
         ftog      <= 1'b0;
         pulse_cnt <= 32'h0000_0000;
      end
      else
      begin
         sec_cnt  <= s_end ? 24'h00_0000 : sec_cnt + 24'h00_0001;
         qsec     <= s_end ? qsec + 2'h1 : qsec;
         sec_tick <= s_end && !count_halted;
         fcnt     <= fcnt + 32'h1 >= f_half ? 32'h0 : fcnt + 32'h1;
         ftog     <= fcnt + 32'h1 >= f_half ? !ftog : ftog;
         if (pulse_load)
            pulse_cnt <= 32'(PULSE_CYC);
         else if (pulse_cnt != 32'h0)
            pulse_cnt <= pulse_cnt - 32'h1;
      end
   end

   // ************************************************************
   // detector and pin state
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         filt_run        <= 1'b0;
         filt_cnt        <= 32'h0000_0000;
         detect_flag     <= 1'b0;
         count_halted    <= 1'b0;
         on_battery      <= 1'b0;
         irq_fout_oe     <= 1'b0;
         tamper_out_n_oe <= 1'b0;
         pullup_en       <= 1'b0;
         cap_code        <= 6'h00;
         cap_delta       <= 2'h0;
      end
      else
      begin
         if (samp_hit && filt_len != 32'h0)
         begin
            filt_run <= 1'b1;
            filt_cnt <= filt_len;
         end
         else if (!tamper_input || filt_cnt <= 32'h1)
            filt_run <= 1'b0;
         else
            filt_cnt <= filt_cnt - 32'h1;
         detect_flag     <= next_detect_flag;
         count_halted    <= next_halted;
         on_battery      <= next_on_battery;
         irq_fout_oe     <= next_pin_low;
         tamper_out_n_oe <= next_out_low;
         pullup_en       <= !dc.input_pullup_off;
         cap_code        <= {!cc.cap_trim[5], cc.cap_trim[4:0]};
         cap_delta       <= next_on_battery ? cc.battery_cap_delta : 2'h0;
      end
   end

   assign irq_fout_o     = 1'b0;
   assign tamper_out_n_o = 1'b0;

   // ************************************************************
   // checks
   // ************************************************************
   sequence s_pulse_start;
      pulse_load && !ac.pin_off_in_battery && !wr_ac;
   endsequence
   sequence s_pulse_hold;
      irq_fout_oe [*8];
   endsequence

   AST_PIN_OFF_BAT: assert property (@(posedge clk) disable iff (!nrst)
      pin_gated |=> !irq_fout_oe) else $error("pin driven while gated on battery");
   AST_SUPPLY_TRIP: assert property (@(posedge clk) disable iff (!nrst)
      vdd_below_hys && !vdd_below_trip && !ac.low_power_switch |=> !on_battery)
      else $error("battery chosen above trip level");
   AST_ALARM_OFF: assert property (@(posedge clk) disable iff (!nrst)
      !ac.alarm_enable && ac.freq_select == 4'h0 |=> !irq_fout_oe) else $error("pin low with alarm off");
   AST_RAW_FREQ: assert property (@(posedge clk) disable iff (!nrst)
      ac.freq_select == 4'h1 && !pin_gated |=> irq_fout_oe == !$past(osc_32k))
      else $error("raw frequency not on pin");
   AST_PULSE: assert property (@(posedge clk) disable iff (!nrst)
      s_pulse_start |-> ##2 s_pulse_hold) else $error("alarm pulse too short");
   AST_SINGLE: assert property (@(posedge clk) disable iff (!nrst)
      alarm_active && !ac.alarm_repeat_select && alarm_flag && !pin_gated |=> irq_fout_oe)
      else $error("single alarm not held low");
   AST_DETECT: assert property (@(posedge clk) disable iff (!nrst)
      dc.detector_on && continuous && tamper_input |=> detect_flag ##0
      (tamper_out_n_oe || (on_battery && $past(dc.detect_out_battery_off))))
      else $error("tamper not flagged");
   AST_NO_DETECT: assert property (@(posedge clk) disable iff (!nrst)
      !dc.detector_on && !detect_flag |=> !detect_flag) else $error("detect while disabled");
   AST_HALT_CLR: assert property (@(posedge clk) disable iff (!nrst)
      time_write_done && !detect_ev && !wr_dc |=> !count_halted && !dc.halt_on_detect)
      else $error("halt not released by time write");
   AST_PULLUP: assert property (@(posedge clk) disable iff (!nrst)
      1'b1 |=> pullup_en == !$past(dc.input_pullup_off)) else $error("pull-up state wrong");
endmodule : rtcatc_top

// file: testbench/rtcatc_far_model.sv
// far side model: outside alarm status bit and the 32.768 kHz oscillator
// assumes the block clock and reset; the status clear comes from the bench
`timescale 1ns/1ps
module rtcatc_far_model #(
   parameter int OSC_HALF = 153
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic alarm_match,
   input  wire logic clr_alarm,
   output logic      alarm_flag,
   output logic      osc_32k
);
   int osc_cnt;
   // ************************************************************
   // status bit set by a match, cleared while clr_alarm is high
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         alarm_flag <= 1'b0;
         osc_32k    <= 1'b0;
         osc_cnt    <= 0;
      end
      else
      begin
         alarm_flag <= alarm_match | (alarm_flag & ~clr_alarm);
         osc_cnt    <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
         osc_32k    <= (osc_cnt == OSC_HALF - 1) ? ~osc_32k : osc_32k;
      end
   end
endmodule : rtcatc_far_model

// file: testbench/test_rtc_alarm_tamper_trim_control.sv
// self-checking bench for the alarm, tamper and trim control block
// assumes shortened counts: pulse 20, filters 4/8/12, second 1000 cycles
`timescale 1ns/1ps
module test_rtc_alarm_tamper_trim_control;
   localparam int PULSE = 20;
   localparam logic [7:0] ADR [5] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h20};
   localparam logic [7:0] WV [4]  = '{8'hB0, 8'h8C, 8'h60, 8'hFF};
   localparam logic [7:0] EV [5]  = '{8'hB0, 8'h8C, 8'h60, 8'h07, 8'h00};
   logic       clk, nrst, reg_wr, vdd_below_hys, vdd_below_trip, alarm_match;
   logic       time_write_done, tamper_input, detect_clr, clr_alarm;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       osc_32k, alarm_flag, on_battery, irq_fout_oe, tamper_out_n_oe, pullup_en;
   logic       sec_tick, count_halted, detect_flag, irq_fout_o, tamper_out_n_o;
   logic [5:0] cap_code;
   logic [1:0] cap_delta;
   int         err_count, n_checks;
   rtcatc_top #(.PULSE_CYC(PULSE), .FILT1_CYC(4), .FILT2_CYC(8), .FILT3_CYC(12), .SEC_CYC(1000)) i_rtcatc_top (
      .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .vdd_below_hys(vdd_below_hys), .vdd_below_trip(vdd_below_trip),
      .osc_32k(osc_32k), .alarm_match(alarm_match), .alarm_flag(alarm_flag),
      .time_write_done(time_write_done), .tamper_input(tamper_input), .detect_clr(detect_clr),
      .on_battery(on_battery), .irq_fout_o(irq_fout_o), .irq_fout_oe(irq_fout_oe), .tamper_out_n_o(tamper_out_n_o),
      .tamper_out_n_oe(tamper_out_n_oe), .pullup_en(pullup_en), .cap_code(cap_code),
      .cap_delta(cap_delta), .sec_tick(sec_tick), .count_halted(count_halted), .detect_flag(detect_flag));
   rtcatc_far_model i_rtcatc_far_model (
      .clk(clk), .nrst(nrst), .alarm_match(alarm_match), .clr_alarm(clr_alarm),
      .alarm_flag(alarm_flag), .osc_32k(osc_32k));
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      @(negedge clk);
      d = reg_rdata;
   endtask : rd
   task automatic match;
      @(negedge clk);
      alarm_match = 1'b1;
      @(negedge clk);
      alarm_match = 1'b0;
      repeat (3) @(negedge clk);
   endtask : match
   task automatic period(input logic [7:0] code, output int p);
      wr(ADR[3], code);
      repeat (3)
      begin
         p = 0;
         do begin @(negedge clk); p++; end while (sec_tick !== 1'b1 && p < 3000);
      end
      chk({7'h0, sec_tick}, 8'h01);
   endtask : period
   task automatic wait_pin(input logic lvl, output int n);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (irq_fout_oe !== lvl && n < 2000);
   endtask : wait_pin
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_regs;
      logic [7:0] v;
      for (int i = 0; i < 5; i++) begin rd(ADR[i], v); chk(v, 8'h00); end
      for (int i = 0; i < 4; i++) wr(ADR[i], WV[i]);
      for (int i = 0; i < 5; i++) begin rd(ADR[i], v); chk(v, EV[i]); end
      chk({2'h0, cap_code}, 8'h00);
      chk({6'h0, irq_fout_o, tamper_out_n_o}, 8'h00);
      chk({7'h0, pullup_en}, 8'h00);
      wr(ADR[2], 8'h1F);
      wr(ADR[1], 8'h00);
      wr(ADR[0], 8'h00);
      chk({2'h0, cap_code}, 8'h3F);
      chk({7'h0, pullup_en}, 8'h01);
   endtask : t_regs
   task automatic t_alarm;
      int n;
      wr(ADR[0], 8'h80);
      match();
      chk({7'h0, irq_fout_oe}, 8'h00);
      wr(ADR[0], 8'hC0);
      n = 0;
      match();
      repeat (60) begin @(negedge clk); n += int'(irq_fout_oe === 1'b1); end
      chk(8'(n + 3), 8'(PULSE));
      wr(ADR[0], 8'h40);
      match();
      repeat (40) @(negedge clk);
      chk({7'h0, irq_fout_oe}, 8'h01);
      clr_alarm = 1'b1;
      match();
      clr_alarm = 1'b0;
      chk({7'h0, irq_fout_oe}, 8'h00);
   endtask : t_alarm
   task automatic t_batt;
      vdd_below_hys = 1'b1;
      match();
      chk({7'h0, on_battery}, 8'h00);
      wr(ADR[0], 8'h70);
      wr(ADR[2], 8'hC0);
      match();
      chk({7'h0, on_battery}, 8'h01);
      chk({6'h0, cap_delta}, 8'h03);
      chk({7'h0, irq_fout_oe}, 8'h00);
      wr(ADR[1], 8'h50);
      tamper_input = 1'b1;
      match();
      chk({7'h0, detect_flag}, 8'h01);
      chk({7'h0, tamper_out_n_oe}, 8'h00);
      wr(ADR[0], 8'h00);
      vdd_below_hys = 1'b0;
      tamper_input  = 1'b0;
      clr_alarm     = 1'b1;
      detect_clr    = 1'b1;
      match();
      clr_alarm  = 1'b0;
      detect_clr = 1'b0;
      chk({7'h0, on_battery}, 8'h00);
      chk({6'h0, cap_delta}, 8'h00);
   endtask : t_batt
   task automatic t_tamper;
      logic [7:0] v;
      int         n;
      wr(ADR[1], 8'h00);
      tamper_input = 1'b1;
      match();
      chk({7'h0, detect_flag}, 8'h00);
      wr(ADR[1], 8'h30);
      match();
      chk({7'h0, tamper_out_n_oe}, 8'h01);
      chk({7'h0, count_halted}, 8'h01);
      tamper_input    = 1'b0;
      detect_clr      = 1'b1;
      time_write_done = 1'b1;
      @(negedge clk);
      detect_clr      = 1'b0;
      time_write_done = 1'b0;
      rd(ADR[1], v);
      chk(v, 8'h10);
      chk({6'h0, count_halted, detect_flag}, 8'h00);
      wr(ADR[1], 8'h15);
      tamper_input = 1'b1;
      n = 0;
      do begin @(negedge clk); n++; end while (detect_flag !== 1'b1 && n < 1500);
      chk({7'h0, detect_flag}, 8'h01);
      tamper_input = 1'b0;
      detect_clr   = 1'b1;
      @(negedge clk);
      detect_clr   = 1'b0;
      wr(ADR[1], 8'h1F);
      chk({7'h0, detect_flag}, 8'h00);
      tamper_input = 1'b1;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (detect_flag !== 1'b1 && n < 7000);
      chk({7'h0, detect_flag}, 8'h01);
      tamper_input = 1'b0;
      wr(ADR[1], 8'h00);
   endtask : t_tamper
   task automatic t_freq;
      int n;
      wr(ADR[0], 8'h41);
      match();
      @(posedge osc_32k);
      repeat (3) @(negedge clk);
      chk({7'h0, irq_fout_oe}, 8'h00);
      @(negedge osc_32k);
      repeat (3) @(negedge clk);
      chk({7'h0, irq_fout_oe}, 8'h01);
      wr(ADR[0], 8'h0A);
      wait_pin(1'b0, n);
      wait_pin(1'b1, n);
      wait_pin(1'b0, n);
      chk({7'h0, n == (1000 + 3 * rtcatc_pkg::TRIM_STEP_CYC) / 2}, 8'h01);
      wr(ADR[0], 8'h00);
   endtask : t_freq
   task automatic t_trim;
      int p0, p1, p4, p5;
      period(8'h00, p0);
      period(8'h04, p4);
      period(8'h01, p1);
      period(8'h05, p5);
      chk({7'h0, p0 == p4}, 8'h01);
      chk({7'h0, p1 < p0}, 8'h01);
      chk({7'h0, p5 > p0}, 8'h01);
   endtask : t_trim
   task automatic results;
      if (err_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results
   // ************************************************************
   // clock, watchdog and main sequence
   // ************************************************************
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      #5_000_000;
      err_count++;
      results();
   end
   initial
   begin
      {nrst, reg_wr, vdd_below_hys, vdd_below_trip, alarm_match} = 5'h00;
      {time_write_done, tamper_input, detect_clr, clr_alarm} = 4'h0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      err_count = 0;
      n_checks  = 0;
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      t_regs();
      t_alarm();
      t_batt();
      t_tamper();
      t_freq();
      t_trim();
      results();
   end
endmodule : test_rtc_alarm_tamper_trim_control
